// ==== rtl/bxu_pkg.sv ====
package bxu_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_WREG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BANK = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_INDEX_BASE = 8'h10;
    localparam logic [7:0] ADDR_INSTR = 8'h14;
    localparam logic [7:0] ADDR_FILE_ADDR = 8'h18;
    localparam logic [7:0] ADDR_FILE_DATA = 8'h1c;
    localparam logic [7:0] ADDR_LAST_EA = 8'h20;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_DIG = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam int STATUS_BUSY = 8;
    localparam int CTRL_EXT_EN = 0;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [11:0] INDEX_BASE_RST = 12'h000;

    // ------------------------------------------------------------
    // Addressing and arithmetic constants
    // ------------------------------------------------------------
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] OV_EDGE = 8'h80;
    localparam int FILE_DEPTH = 4096;

    // ------------------------------------------------------------
    // Operations and state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        decimal_adjust_accumulator = 2'h0,
        rotate_right_no_carry_file = 2'h1,
        decrement_file = 2'h2,
        set_file_all_ones = 2'h3
    } bxu_op_t;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_DECODE = 5'h02,
        ST_READ = 5'h04,
        ST_PROC = 5'h08,
        ST_WRITE = 5'h10
    } bxu_state_t;

    typedef struct packed
    {
        bxu_op_t op;
        logic dest;
        logic access_sel;
        logic [7:0] faddr;
    } bxu_instr_t;

    typedef struct packed
    {
        logic [7:0] value;
        logic [4:0] flags;
    } bxu_result_t;

endpackage

// ==== rtl/bxu_alu.sv ====
module bxu_alu
    import bxu_pkg::*;
(
    input wire bxu_op_t op_i,        // Operation
    input wire logic [7:0] opnd_i,   // Operand byte
    input wire logic [4:0] flags_i,  // Flags before
    output bxu_result_t result_o     // Result and flags
);

    logic [8:0] adj;
    logic lo_fix;
    logic hi_fix;
    logic [7:0] dec;

    always_comb
    begin
        lo_fix = (opnd_i[3:0] > BCD_DIGIT_MAX) || flags_i[FLAG_DIG];
        adj = {1'b0, opnd_i};
        if (lo_fix)
        begin
            // Carry out of the low fix must reach the high digit
            adj = {1'b0, opnd_i} + {5'h00, BCD_FIX};
        end
        hi_fix = (adj[7:4] > BCD_DIGIT_MAX) || flags_i[FLAG_C]
            || adj[8];
        if (hi_fix)
        begin
            adj = {1'b0, adj[7:4], 4'h0} + {1'b0, BCD_FIX, 4'h0}
                + {5'h00, adj[3:0]};
        end
        dec = opnd_i - 8'h01;
        result_o.value = opnd_i;
        result_o.flags = flags_i;
        case (op_i)
            decimal_adjust_accumulator:
            begin
                result_o.value = adj[7:0];
                result_o.flags[FLAG_C] = adj[8] | hi_fix;
            end
            rotate_right_no_carry_file:
            begin
                result_o.value = {opnd_i[0], opnd_i[7:1]};
                result_o.flags[FLAG_N] = opnd_i[0];
                result_o.flags[FLAG_Z] = (opnd_i == 8'h00);
            end
            decrement_file:
            begin
                result_o.value = dec;
                result_o.flags[FLAG_C] = (opnd_i != 8'h00);
                result_o.flags[FLAG_DIG] = (opnd_i[3:0] != 4'h0);
                result_o.flags[FLAG_OV] = (opnd_i == OV_EDGE);
                result_o.flags[FLAG_N] = dec[7];
                result_o.flags[FLAG_Z] = (dec == 8'h00);
            end
            set_file_all_ones:
            begin
                result_o.value = ALL_ONES;
            end
            default:
            begin
                result_o.value = opnd_i;
            end
        endcase
    end

endmodule

// ==== rtl/bxu_top.sv ====
// Overview of operation
// - Decimal adjust adds 6 to the low nibble if above 9 or digit carry.
// - Rotate right moves the byte down one place, old bit 0 to bit 7.
// - Destination bit 0 writes the result to W, 1 to the file register; decimal adjust always writes W, set all ones always the file.
// - Access bit 0 addresses the fixed access area, ignoring the bank.
// - Access bit 1 addresses the bank register's bank at the file field.
// - Extended set, access bit 0 and field up to 95 use indexed offset.
module bxu_top
    import bxu_pkg::*;
(
    input wire logic clock_i,        // 20 MHz clock
    input wire logic rst_n_i,        // Async reset, low
    input wire logic psel_i,         // APB select
    input wire logic penable_i,      // APB enable
    input wire logic pwrite_i,       // APB direction
    input wire logic [7:0] paddr_i,  // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o,    // APB read data
    output logic pready_o,           // APB ready
    output logic pslverr_o           // APB error
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] file_mem [FILE_DEPTH];
    logic [7:0] wreg;
    logic [4:0] flags;
    logic [3:0] bank_select_reg;
    logic ext_en;
    logic [11:0] index_base;
    logic [11:0] file_addr;
    bxu_instr_t instr;
    logic [11:0] eff_addr;
    logic [11:0] next_eff_addr;
    logic [7:0] opnd;
    bxu_result_t result;
    bxu_result_t alu_out;
    bxu_state_t state;
    logic ready_q;
    logic err_q;
    logic [31:0] rd_mux;
    logic rd_err;
    logic apb_write;
    logic start;
    logic idle;

    assign idle = (state == ST_IDLE);
    assign pready_o = penable_i & ready_q;
    assign apb_write = psel_i & penable_i & pready_o & pwrite_i;
    assign start = apb_write && (paddr_i == ADDR_INSTR);

    // ------------------------------------------------------------
    // APB read path and answer
    // ------------------------------------------------------------
    // Read data is sampled only while idle, so a stalled read
    // never returns a value from before the write-back.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr_i)
            ADDR_WREG: rd_mux = {24'h00_0000, wreg};
            ADDR_STATUS: rd_mux = {23'h00_0000, ~idle, 3'h0, flags};
            ADDR_BANK: rd_mux = {28'h000_0000, bank_select_reg};
            ADDR_CTRL: rd_mux = {31'h0000_0000, ext_en};
            ADDR_INDEX_BASE: rd_mux = {20'h0_0000, index_base};
            ADDR_INSTR: rd_mux = {20'h0_0000, instr};
            ADDR_FILE_ADDR: rd_mux = {20'h0_0000, file_addr};
            ADDR_FILE_DATA: rd_mux = {24'h00_0000, file_mem[file_addr]};
            ADDR_LAST_EA: rd_mux = {20'h0_0000, eff_addr};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            if (pready_o)
            begin
                ready_q <= 1'b0;
            end
            else if (psel_i && idle)
            begin
                ready_q <= 1'b1;
                err_q <= rd_err;
                prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign pslverr_o = pready_o & err_q;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bank_select_reg <= BANK_RST;
            ext_en <= 1'b0;
            index_base <= INDEX_BASE_RST;
            file_addr <= 12'h000;
            instr <= '0;
        end
        else if (apb_write)
        begin
            case (paddr_i)
                ADDR_BANK: bank_select_reg <= pwdata_i[3:0];
                ADDR_CTRL: ext_en <= pwdata_i[CTRL_EXT_EN];
                ADDR_INDEX_BASE: index_base <= pwdata_i[11:0];
                ADDR_INSTR: instr <= bxu_instr_t'(pwdata_i[11:0]);
                ADDR_FILE_ADDR: file_addr <= pwdata_i[11:0];
                default: file_addr <= file_addr;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            case (state)
                ST_IDLE: state <= start ? ST_DECODE : ST_IDLE;
                ST_DECODE: state <= ST_READ;
                ST_READ: state <= ST_PROC;
                ST_PROC: state <= ST_WRITE;
                ST_WRITE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Operand address
    // ------------------------------------------------------------
    always_comb
    begin
        if (instr.access_sel)
        begin
            next_eff_addr = {bank_select_reg, instr.faddr};
        end
        else if (ext_en && (instr.faddr <= INDEXED_MAX))
        begin
            next_eff_addr = index_base + {4'h0, instr.faddr};
        end
        else if (instr.faddr < ACCESS_SPLIT)
        begin
            next_eff_addr = {ACCESS_LOW_BANK, instr.faddr};
        end
        else
        begin
            next_eff_addr = {ACCESS_HIGH_BANK, instr.faddr};
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            eff_addr <= 12'h000;
        end
        else if (state == ST_DECODE)
        begin
            eff_addr <= next_eff_addr;
        end
    end

    // ------------------------------------------------------------
    // Read, process
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            opnd <= 8'h00;
        end
        else if (state == ST_READ)
        begin
            opnd <= (instr.op == decimal_adjust_accumulator) ?
                wreg : file_mem[eff_addr];
        end
    end

    bxu_alu bxu_alu_i
    (
        .op_i(instr.op),
        .opnd_i(opnd),
        .flags_i(flags),
        .result_o(alu_out)
    );

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            result <= '0;
        end
        else if (state == ST_PROC)
        begin
            result <= alu_out;
        end
    end

    // ------------------------------------------------------------
    // Write-back
    // ------------------------------------------------------------
    // The bus is stalled during execution, so software and the
    // write-back never collide on W, flags or memory.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wreg <= WREG_RST;
            flags <= FLAGS_RST;
        end
        else if (state == ST_WRITE)
        begin
            flags <= result.flags;
            if (instr.op == decimal_adjust_accumulator)
            begin
                wreg <= result.value;
            end
            else if (!instr.dest && instr.op != set_file_all_ones)
            begin
                wreg <= result.value;
            end
        end
        else if (apb_write && paddr_i == ADDR_WREG)
        begin
            wreg <= pwdata_i[7:0];
        end
        else if (apb_write && paddr_i == ADDR_STATUS)
        begin
            flags <= pwdata_i[4:0];
        end
    end

    // Memory has no reset; contents are undefined until written.
    always_ff @(posedge clock_i)
    begin
        if (state == ST_WRITE && instr.op != decimal_adjust_accumulator
            && (instr.dest || instr.op == set_file_all_ones))
        begin
            file_mem[eff_addr] <= result.value;
        end
        else if (apb_write && paddr_i == ADDR_FILE_DATA)
        begin
            file_mem[file_addr] <= pwdata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic is_write;
    assign is_write = (state == ST_WRITE);

    sequence s_exec;
        (state == ST_DECODE) ##1 (state == ST_READ) ##1
        (state == ST_PROC) ##1 (state == ST_WRITE) ##1 idle;
    endsequence

    a_exec_steps:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        start |=> s_exec)
    else $error("execution did not take four steps");

    a_decadj_low_nib:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        is_write && instr.op == decimal_adjust_accumulator
        |=> wreg[3:0] == ((opnd[3:0] > 4'h9 || $past(flags[FLAG_DIG])) ?
            opnd[3:0] + 4'h6 : opnd[3:0]))
    else $error("decimal adjust low nibble wrong");

    a_decadj_carry:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        is_write && instr.op == decimal_adjust_accumulator
        && opnd > 8'h99 |=> flags[FLAG_C] && wreg == opnd +
            ((opnd[3:0] > 4'h9 || $past(flags[FLAG_DIG])) ? 8'h66 : 8'h60))
    else $error("decimal adjust high nibble or carry wrong");

    a_rot_right:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        is_write && instr.op == rotate_right_no_carry_file && instr.dest
        |=> file_mem[eff_addr] == {opnd[0], opnd[7:1]})
    else $error("rotate right result wrong");

    a_dest_wreg:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        is_write && instr.op == decrement_file && !instr.dest
        |=> wreg == opnd - 8'h01 && file_mem[eff_addr] == opnd)
    else $error("destination W not honoured");

    a_access_fixed:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == ST_DECODE && !instr.access_sel
        && !(ext_en && instr.faddr <= 8'h5f)
        |=> eff_addr == {(instr.faddr < 8'h60) ? 4'h0 : 4'hf, instr.faddr})
    else $error("access area address wrong");

    a_bank_addr:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == ST_DECODE && instr.access_sel
        |=> eff_addr == {$past(bank_select_reg), instr.faddr})
    else $error("banked address wrong");

    a_indexed_addr:
    assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == ST_DECODE && !instr.access_sel && ext_en
        && instr.faddr <= 8'h5f
        |=> eff_addr == index_base + {4'h0, instr.faddr})
    else $error("indexed literal offset address wrong");

endmodule

// ==== tb/test_byte_op_execute_unit.sv ====
module test_byte_op_execute_unit
    import bxu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Clock, reset and bus signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int mismatches = 0;
    int checks_done = 0;

    always #25 clk = ~clk;

    bxu_top bxu_top_i (
        .clock_i(clk),
        .rst_n_i(rst_n),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr)
    );

    // ------------------------------------------------------------
    // Report and compare
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------
    // Ready is read right after the rising edge, before that edge's
    // updates land, so it is the value the edge itself sampled.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        bit done;
        done = 1'b0;
        rd = 32'h0;
        err = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 60 && !done; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                err = pslverr;
                done = 1'b1;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done)
        begin
            mismatches++;
            $display("MISMATCH ready expected 1 seen 0");
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(n, exp, r);
    endtask

    task automatic fset(input logic [11:0] a, input logic [7:0] d);
        wr(ADDR_FILE_ADDR, {20'h0, a});
        wr(ADDR_FILE_DATA, {24'h0, d});
    endtask

    task automatic fchk(input string n, input logic [11:0] a,
                        input logic [7:0] exp);
        wr(ADDR_FILE_ADDR, {20'h0, a});
        rdc(n, ADDR_FILE_DATA, {24'h0, exp});
    endtask

    task automatic exec(input bxu_op_t op, input logic d, input logic a,
                        input logic [7:0] f);
        bxu_instr_t ins;
        ins = '{op: op, dest: d, access_sel: a, faddr: f};
        wr(ADDR_INSTR, {20'h0, ins});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rdc("w_rst", ADDR_WREG, 32'h0);
        rdc("status_rst", ADDR_STATUS, 32'h0);
        rdc("bank_rst", ADDR_BANK, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_rd", 32'h0, r);
    endtask

    // High fix, low fix, digit carry and carry inputs, each in turn
    task automatic t_decadj;
        logic [7:0] win[4] = '{8'ha5, 8'hce, 8'h12, 8'h12};
        logic [7:0] fin[4] = '{8'h00, 8'h00, 8'h02, 8'h01};
        logic [7:0] wout[4] = '{8'h05, 8'h34, 8'h18, 8'h72};
        logic cout[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_WREG, {24'h0, win[i]});
            wr(ADDR_STATUS, {24'h0, fin[i]});
            exec(decimal_adjust_accumulator, 1'b0, 1'b0, 8'h00);
            rdc("daa_w", ADDR_WREG, {24'h0, wout[i]});
            apb(1'b0, ADDR_STATUS, 32'h0, r, e);
            chk("daa_c", {31'h0, cout[i]}, {31'h0, r[FLAG_C]});
        end
    endtask

    task automatic t_rotate;
        wr(ADDR_BANK, 32'h2);
        wr(ADDR_WREG, 32'h5a);
        fset(12'h233, 8'hd7);
        exec(rotate_right_no_carry_file, 1'b1, 1'b1, 8'h33);
        fchk("rot_file", 12'h233, 8'heb);
        rdc("rot_w_kept", ADDR_WREG, 32'h5a);
        rdc("rot_ea", ADDR_LAST_EA, 32'h233);
        exec(rotate_right_no_carry_file, 1'b0, 1'b1, 8'h33);
        rdc("rot_w", ADDR_WREG, 32'hf5);
        fchk("rot_file_kept", 12'h233, 8'heb);
    endtask

    // Bank register holds 2 throughout and must be ignored
    task automatic t_access;
        wr(ADDR_STATUS, 32'h0);
        fset(12'h270, 8'h11);
        exec(set_file_all_ones, 1'b0, 1'b0, 8'h70);
        fchk("set_high", 12'hf70, 8'hff);
        fchk("set_bank_kept", 12'h270, 8'h11);
        rdc("set_ea", ADDR_LAST_EA, 32'hf70);
        fset(12'h010, 8'h01);
        exec(decrement_file, 1'b1, 1'b0, 8'h10);
        fchk("dec_low", 12'h010, 8'h00);
        rdc("dec_flags", ADDR_STATUS, 32'h07);
        rdc("dec_ea", ADDR_LAST_EA, 32'h010);
        exec(decrement_file, 1'b0, 1'b0, 8'h10);
        rdc("dec_w", ADDR_WREG, 32'hff);
        fchk("dec_file_kept", 12'h010, 8'h00);
        rdc("dec_w_flags", ADDR_STATUS, 32'h10);
    endtask

    // Field 0x5f is the last indexed address, 0x60 the first plain one
    task automatic t_indexed;
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_INDEX_BASE, 32'h300);
        wr(ADDR_STATUS, 32'h0);
        fset(12'h35f, 8'h80);
        exec(decrement_file, 1'b1, 1'b0, 8'h5f);
        fchk("idx_file", 12'h35f, 8'h7f);
        rdc("idx_ea", ADDR_LAST_EA, 32'h35f);
        rdc("idx_flags", ADDR_STATUS, 32'h09);
        exec(set_file_all_ones, 1'b0, 1'b0, 8'h60);
        rdc("idx_edge_ea", ADDR_LAST_EA, 32'hf60);
        exec(set_file_all_ones, 1'b0, 1'b1, 8'h5f);
        rdc("idx_banked_ea", ADDR_LAST_EA, 32'h25f);
        rdc("instr_rb", ADDR_INSTR, 32'hd5f);
        rdc("base_rb", ADDR_INDEX_BASE, 32'h300);
        rdc("ctrl_rb", ADDR_CTRL, 32'h1);
        wr(ADDR_CTRL, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_decadj();
        t_rotate();
        t_access();
        t_indexed();
        wrap_up();
    end
endmodule
